// >>> design/dbsm_pkg.sv
package dbsm_pkg;
  // ---------------------------------------------------------------
  // Register map (index; byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] DBSM_IDX_POWER = 8'h12;
  localparam logic [7:0] DBSM_IDX_IFACE = 8'h18;
  localparam logic [7:0] DBSM_IDX_SIDE = 8'h20;
  localparam logic [7:0] DBSM_IDX_STATUS = 8'h21;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int DBSM_LEFT_ON_BIT = 3;
  localparam int DBSM_RIGHT_ON_BIT = 2;
  localparam int DBSM_BOOST_LSB = 9;
  localparam int DBSM_LEFT_CHSEL_BIT = 5;
  localparam int DBSM_RIGHT_CHSEL_BIT = 4;
  localparam int DBSM_LEFT_LVL_LSB = 8;
  localparam int DBSM_RIGHT_LVL_LSB = 4;
  localparam int DBSM_LEFT_SRC_LSB = 2;
  localparam int DBSM_RIGHT_SRC_LSB = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DBSM_BOOST_RST = 2'h0;
  localparam logic DBSM_LEFT_CHSEL_RST = 1'b0;
  localparam logic DBSM_RIGHT_CHSEL_RST = 1'b1;
  localparam logic [3:0] DBSM_LVL_RST = 4'h0;
  localparam logic [1:0] DBSM_SRC_RST = 2'h0;
  localparam logic DBSM_ON_RST = 1'b0;

  // ---------------------------------------------------------------
  // Datapath sizes
  // ---------------------------------------------------------------
  localparam int DBSM_SAMPLE_W = 24;
  localparam int DBSM_FIFO_DEPTH = 16;
  localparam int DBSM_COEF_FRAC = 15;
  localparam logic signed [27:0] DBSM_POS_FULL = 28'sh07F_FFFF;
  localparam logic signed [27:0] DBSM_NEG_FULL = -28'sh080_0000;

  // Sidetone source encodings
  typedef enum logic [1:0] {
    DBSM_SRC_NONE = 2'h0,
    DBSM_SRC_LEFT = 2'h1,
    DBSM_SRC_RIGHT = 2'h2,
    DBSM_SRC_RSVD = 2'h3
  } dbsm_src_t;

  typedef struct packed {
    logic signed [DBSM_SAMPLE_W-1:0] left;
    logic signed [DBSM_SAMPLE_W-1:0] right;
  } dbsm_pair_t;

  // Sidetone gain in Q1.15, -36 dB to 0 dB in 3 dB steps
  function automatic logic [16:0] dbsm_side_coef(input logic [3:0] lvl);
    logic [16:0] c;
    c = 17'h0_8000;
    unique case (lvl)
      4'h0: c = 17'h0_0207;
      4'h1: c = 17'h0_02DD;
      4'h2: c = 17'h0_040C;
      4'h3: c = 17'h0_05B8;
      4'h4: c = 17'h0_0814;
      4'h5: c = 17'h0_0B68;
      4'h6: c = 17'h0_101D;
      4'h7: c = 17'h0_16C3;
      4'h8: c = 17'h0_2027;
      4'h9: c = 17'h0_2D6B;
      4'hA: c = 17'h0_4027;
      4'hB: c = 17'h0_5A9E;
      default: c = 17'h0_8000;
    endcase
    return c;
  endfunction
endpackage

// >>> design/dbsm_mixer.sv
// Notes on behaviour
// - Playback samples gain 0, +6, +12 or +18 dB from a two-bit boost field.
// - Boost acts on interface playback data before it reaches the converter input.
// - Sidetone is mixed only while converter and capture sample rates match.
// - Sidetone samples come from the capture high-pass filter output.
// - Each converter channel adds its own selected sidetone; any source to any channel.
// - Left capture sidetone scaled -36 dB to 0 dB in 3 dB codes; reset 0000.
// - Right capture sidetone scaled with the same mapping; reset 0000.
// - Left converter sidetone source: none, left, right, reserved; reset 00.
// - Right converter sidetone source, same encoding; reset 00.
// - Each converter runs only while its enable bit is set; both reset off.
// - Summed samples leave at 24-bit precision toward interpolation.
// - Converter channel select picks left or right interface data; right resets to 1.
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Playback FIFO
// ---------------------------------------------------------------
module dbsm_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Synchronous reset
  input wire logic ce_in, // Clock enable
  input wire logic in_valid_in, // Write request
  output logic in_ready_out, // Room for a word
  input wire logic [WIDTH-1:0] in_data_in, // Write data
  output logic out_valid_out, // Word available
  input wire logic out_ready_in, // Read accept
  output logic [WIDTH-1:0] out_data_out, // Head word
  output logic [$clog2(DEPTH):0] count_out // Fill level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_valid_out = (count_out != '0);
  assign out_data_out = mem[rd_ptr];
  assign next_count = count_out + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_out <= '0;
      in_ready_out <= 1'b0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count_out <= next_count;
      // Registered so the source sees back-pressure from a flop
      in_ready_out <= (next_count != FULL);
    end
  end
endmodule // dbsm_fifo

// ---------------------------------------------------------------
// Boost and sidetone mixer
// ---------------------------------------------------------------
module dbsm_mixer
  import dbsm_pkg::*;
(
  input wire logic REF_CLK_IN, // Core clock
  input wire logic RESET_IN, // Synchronous reset, high
  input wire logic CLK_EN_IN, // Freezes all state when low
  input wire logic PSEL_IN, // APB select
  input wire logic PENABLE_IN, // APB enable
  input wire logic PWRITE_IN, // APB direction
  input wire logic [9:0] PADDR_IN, // APB byte address
  input wire logic [31:0] PWDATA_IN, // APB write data
  output logic [31:0] PRDATA_OUT, // APB read data
  output logic PREADY_OUT, // APB ready
  output logic PSLVERR_OUT, // APB error
  input wire logic PLAY_VALID_IN, // Serial playback input sample valid
  input wire dbsm_pair_t PLAY_DATA_IN, // Serial playback input stereo sample
  output logic PLAY_READY_OUT, // Playback FIFO has room
  input wire logic HPF_VALID_IN, // Capture high-pass output valid
  input wire dbsm_pair_t HPF_DATA_IN, // Capture high-pass output sample
  input wire logic RATE_MATCH_IN, // Capture and playback rates equal
  output logic DAC_VALID_OUT, // Mixed sample valid
  output dbsm_pair_t DAC_DATA_OUT, // Mixed sample to interpolation
  input wire logic DAC_READY_IN, // Interpolation accepts sample
  output logic LEFT_CONVERTER_ON_OUT, // Left converter enable
  output logic RIGHT_CONVERTER_ON_OUT // Right converter enable
);
  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic left_converter_on;
  logic right_converter_on;
  logic [1:0] boost;
  logic left_converter_channel_select;
  logic right_converter_channel_select;
  logic [3:0] left_sidetone_level;
  logic [3:0] right_sidetone_level;
  logic [1:0] left_dac_sidetone_select;
  logic [1:0] right_dac_sidetone_select;

  logic access;
  logic addr_ok;
  logic [7:0] idx;
  logic [31:0] rd_word;
  logic write_now;

  assign access = PSEL_IN && PENABLE_IN;
  assign idx = PADDR_IN[9:2];
  assign write_now = access && PREADY_OUT && PWRITE_IN && !PSLVERR_OUT;

  logic [4:0] fifo_count;
  logic fifo_valid;
  dbsm_pair_t fifo_data;
  logic take;

  always_comb begin
    rd_word = 32'h0000_0000;
    addr_ok = (PADDR_IN[1:0] == 2'b00);
    unique case (idx)
      DBSM_IDX_POWER: begin
        rd_word[DBSM_LEFT_ON_BIT] = left_converter_on;
        rd_word[DBSM_RIGHT_ON_BIT] = right_converter_on;
      end
      DBSM_IDX_IFACE: begin
        rd_word[DBSM_BOOST_LSB +: 2] = boost;
        rd_word[DBSM_LEFT_CHSEL_BIT] = left_converter_channel_select;
        rd_word[DBSM_RIGHT_CHSEL_BIT] = right_converter_channel_select;
      end
      DBSM_IDX_SIDE: begin
        rd_word[DBSM_LEFT_LVL_LSB +: 4] = left_sidetone_level;
        rd_word[DBSM_RIGHT_LVL_LSB +: 4] = right_sidetone_level;
        rd_word[DBSM_LEFT_SRC_LSB +: 2] = left_dac_sidetone_select;
        rd_word[DBSM_RIGHT_SRC_LSB +: 2] = right_dac_sidetone_select;
      end
      DBSM_IDX_STATUS: begin
        rd_word[4:0] = fifo_count;
        rd_word[8] = DAC_VALID_OUT;
        rd_word[9] = RATE_MATCH_IN;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // Ready comes one cycle into the access phase; write lands on the next edge, while ready is high
  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0000_0000;
    end else if (CLK_EN_IN) begin
      PREADY_OUT <= access && !PREADY_OUT;
      PSLVERR_OUT <= access && !PREADY_OUT && !addr_ok;
      if (access && !PREADY_OUT) begin
        PRDATA_OUT <= (addr_ok && !PWRITE_IN) ? rd_word : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      left_converter_on <= DBSM_ON_RST;
      right_converter_on <= DBSM_ON_RST;
      boost <= DBSM_BOOST_RST;
      left_converter_channel_select <= DBSM_LEFT_CHSEL_RST;
      right_converter_channel_select <= DBSM_RIGHT_CHSEL_RST;
      left_sidetone_level <= DBSM_LVL_RST;
      right_sidetone_level <= DBSM_LVL_RST;
      left_dac_sidetone_select <= DBSM_SRC_RST;
      right_dac_sidetone_select <= DBSM_SRC_RST;
    end else if (CLK_EN_IN && write_now) begin
      unique case (idx)
        DBSM_IDX_POWER: begin
          left_converter_on <= PWDATA_IN[DBSM_LEFT_ON_BIT];
          right_converter_on <= PWDATA_IN[DBSM_RIGHT_ON_BIT];
        end
        DBSM_IDX_IFACE: begin
          boost <= PWDATA_IN[DBSM_BOOST_LSB +: 2];
          left_converter_channel_select <= PWDATA_IN[DBSM_LEFT_CHSEL_BIT];
          right_converter_channel_select <= PWDATA_IN[DBSM_RIGHT_CHSEL_BIT];
        end
        DBSM_IDX_SIDE: begin
          left_sidetone_level <= PWDATA_IN[DBSM_LEFT_LVL_LSB +: 4];
          right_sidetone_level <= PWDATA_IN[DBSM_RIGHT_LVL_LSB +: 4];
          left_dac_sidetone_select <= PWDATA_IN[DBSM_LEFT_SRC_LSB +: 2];
          right_dac_sidetone_select <= PWDATA_IN[DBSM_RIGHT_SRC_LSB +: 2];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      LEFT_CONVERTER_ON_OUT <= DBSM_ON_RST;
      RIGHT_CONVERTER_ON_OUT <= DBSM_ON_RST;
    end else if (CLK_EN_IN) begin
      LEFT_CONVERTER_ON_OUT <= left_converter_on;
      RIGHT_CONVERTER_ON_OUT <= right_converter_on;
    end
  end

  // ---------------------------------------------------------------
  // Sidetone capture
  // ---------------------------------------------------------------
  // Latest filtered capture sample; held so playback and capture strobes
  // need not coincide when both run at one rate
  dbsm_pair_t side_hold;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      side_hold <= '0;
    end else if (CLK_EN_IN && HPF_VALID_IN) begin
      side_hold <= HPF_DATA_IN;
    end
  end

  // ---------------------------------------------------------------
  // Playback path
  // ---------------------------------------------------------------
  dbsm_fifo #(
    .WIDTH($bits(dbsm_pair_t)),
    .DEPTH(DBSM_FIFO_DEPTH)
  ) u_play_fifo (
    .clk_in(REF_CLK_IN),
    .rst_in(RESET_IN),
    .ce_in(CLK_EN_IN),
    .in_valid_in(PLAY_VALID_IN),
    .in_ready_out(PLAY_READY_OUT),
    .in_data_in(PLAY_DATA_IN),
    .out_valid_out(fifo_valid),
    .out_ready_in(take),
    .out_data_out(fifo_data),
    .count_out(fifo_count)
  );

  assign take = fifo_valid && (!DAC_VALID_OUT || DAC_READY_IN);

  function automatic logic signed [27:0] side_term(
    input dbsm_pair_t st,
    input logic [1:0] src,
    input logic [3:0] lvl_l,
    input logic [3:0] lvl_r,
    input logic rates_ok
  );
    logic signed [41:0] p;
    p = '0;
    if (rates_ok) begin
      unique case (dbsm_src_t'(src))
        DBSM_SRC_LEFT: p = st.left * $signed({1'b0, dbsm_side_coef(lvl_l)});
        DBSM_SRC_RIGHT: p = st.right * $signed({1'b0, dbsm_side_coef(lvl_r)});
        default: p = '0; // Reserved code mixes nothing
      endcase
    end
    return 28'(p >>> DBSM_COEF_FRAC);
  endfunction

  function automatic logic signed [DBSM_SAMPLE_W-1:0] mix(
    input logic signed [DBSM_SAMPLE_W-1:0] s,
    input logic [1:0] gain,
    input logic signed [27:0] side,
    input logic on
  );
    logic signed [27:0] v;
    logic signed [DBSM_SAMPLE_W-1:0] r;
    // Each boost step doubles: +6 dB
    v = (28'(s) <<< gain) + side;
    if (v > DBSM_POS_FULL) begin
      r = DBSM_POS_FULL[DBSM_SAMPLE_W-1:0];
    end else if (v < DBSM_NEG_FULL) begin
      r = DBSM_NEG_FULL[DBSM_SAMPLE_W-1:0];
    end else begin
      r = v[DBSM_SAMPLE_W-1:0];
    end
    return on ? r : '0;
  endfunction

  logic signed [DBSM_SAMPLE_W-1:0] left_in;
  logic signed [DBSM_SAMPLE_W-1:0] right_in;

  assign left_in = left_converter_channel_select ? fifo_data.right : fifo_data.left;
  assign right_in = right_converter_channel_select ? fifo_data.right : fifo_data.left;

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      DAC_VALID_OUT <= 1'b0;
      DAC_DATA_OUT <= '0;
    end else if (CLK_EN_IN) begin
      if (take) begin
        DAC_VALID_OUT <= 1'b1;
        DAC_DATA_OUT.left <= mix(left_in, boost, side_term(side_hold,
          left_dac_sidetone_select, left_sidetone_level, right_sidetone_level,
          RATE_MATCH_IN), left_converter_on);
        DAC_DATA_OUT.right <= mix(right_in, boost, side_term(side_hold,
          right_dac_sidetone_select, left_sidetone_level, right_sidetone_level,
          RATE_MATCH_IN), right_converter_on);
      end else if (DAC_READY_IN) begin
        DAC_VALID_OUT <= 1'b0;
      end
    end
  end
endmodule // dbsm_mixer

// >>> tb/dbsm_mixer_asserts.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module dbsm_mixer_asserts (
  input wire logic REF_CLK_IN, // Clock
  input wire logic RESET_IN, // Reset
  input wire logic PSEL_IN, // Select
  input wire logic PENABLE_IN, // Enable
  input wire logic PWRITE_IN, // Direction
  input wire logic [9:0] PADDR_IN, // Address
  input wire logic [31:0] PWDATA_IN, // Write data
  input wire logic [31:0] PRDATA_OUT, // Read data
  input wire logic PREADY_OUT, // Ready
  input wire logic PSLVERR_OUT, // Error
  input wire logic PLAY_READY_OUT, // Room
  input wire logic DAC_VALID_OUT, // Out valid
  input wire dbsm_pkg::dbsm_pair_t DAC_DATA_OUT, // Out data
  input wire logic DAC_READY_IN, // Out ready
  input wire logic LEFT_CONVERTER_ON_OUT, // Left on
  input wire logic RIGHT_CONVERTER_ON_OUT // Right on
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  one_wait_a: assert property (PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
    else $error("ready late");
  ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held");
  bad_addr_a: assert property (PREADY_OUT |->
    PSLVERR_OUT == !(PADDR_IN inside {10'h048, 10'h060, 10'h080, 10'h084}))
    else $error("error flag wrong");
  err_read_zero_a: assert property (PSLVERR_OUT && !PWRITE_IN |-> PRDATA_OUT == 32'h0000_0000)
    else $error("refused read not zero");
  dac_hold_a: assert property (DAC_VALID_OUT && !DAC_READY_IN |=>
    DAC_VALID_OUT && $stable(DAC_DATA_OUT)) else $error("output dropped");
  play_ready_a: assert property ($fell(RESET_IN) |=> PLAY_READY_OUT)
    else $error("not ready after reset");
  reset_quiet_a: assert property (disable iff (1'b0) RESET_IN |=> !PREADY_OUT &&
    !DAC_VALID_OUT && !PLAY_READY_OUT && !LEFT_CONVERTER_ON_OUT && !RIGHT_CONVERTER_ON_OUT)
    else $error("outputs live in reset");
  power_follow_a: assert property (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
    PADDR_IN == 10'h048 |-> ##2
    {LEFT_CONVERTER_ON_OUT, RIGHT_CONVERTER_ON_OUT} == $past(PWDATA_IN[3:2], 2))
    else $error("enable not followed");
  power_read_a: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == 10'h048 |->
    PRDATA_OUT == {28'h000_0000, LEFT_CONVERTER_ON_OUT, RIGHT_CONVERTER_ON_OUT, 2'h0})
    else $error("power readback wrong");
  cover property (!PLAY_READY_OUT);
  cover property (PSLVERR_OUT);
  cover property (DAC_VALID_OUT && DAC_READY_IN && DAC_DATA_OUT.left == 24'h7F_FFFF);
endmodule // dbsm_mixer_asserts

bind dbsm_mixer dbsm_mixer_asserts dbsm_mixer_asserts_inst (.*);

// >>> tb/dbsm_play_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Playback source
// ----------------------------------------
module dbsm_play_src
  import dbsm_pkg::*;
(
  input wire logic clk_in, // Clock
  input wire logic ready_in, // Sink ready
  output logic valid_out, // Sample valid
  output dbsm_pair_t data_out // Sample
);
  initial begin
    valid_out = 1'b0;
    data_out = '0;
  end
  // Released data shows its inverse so stale words cannot pass
  task automatic send(input dbsm_pair_t p);
    @(posedge clk_in);
    valid_out <= 1'b1;
    data_out <= p;
    for (int k = 0; k < 2000; k++) begin
      @(posedge clk_in);
      if (ready_in === 1'b1) break;
    end
    valid_out <= 1'b0;
    data_out <= ~p;
  endtask
endmodule // dbsm_play_src

// >>> tb/dbsm_mixer_tb.sv
`timescale 1ns/1ps
module dbsm_mixer_tb;
  import dbsm_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, hv = 1'b0, rate = 1'b0;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32'h0000_CC18;
  logic pready, pslverr, prdy, pv, dv, drdy = 1'b0, lon, ron, stall = 1'b0;
  dbsm_pair_t hd = '0, pd, dd, hs = '0;
  dbsm_pair_t q[$];
  logic [1:0] g = 2'h0, lsrc = 2'h0, rsrc = 2'h0;
  logic [3:0] llvl = 4'h0, rlvl = 4'h0;
  logic lsel = 1'b0, rsel = 1'b1, lon_m = 1'b0, ron_m = 1'b0;
  int mismatches = 0, tests_run = 0;
  dbsm_mixer dbsm_mixer_inst (.REF_CLK_IN(clk), .RESET_IN(rst), .CLK_EN_IN(1'b1),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PLAY_VALID_IN(pv),
    .PLAY_DATA_IN(pd), .PLAY_READY_OUT(prdy), .HPF_VALID_IN(hv), .HPF_DATA_IN(hd),
    .RATE_MATCH_IN(rate), .DAC_VALID_OUT(dv), .DAC_DATA_OUT(dd), .DAC_READY_IN(drdy),
    .LEFT_CONVERTER_ON_OUT(lon), .RIGHT_CONVERTER_ON_OUT(ron));
  dbsm_play_src dbsm_play_src_inst (.clk_in(clk), .ready_in(prdy), .valid_out(pv),
    .data_out(pd));
  initial forever #4 clk = ~clk;
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function dbsm_pair_t rp();
    dbsm_pair_t r;
    r.left = 24'(rnd());
    r.right = 24'(rnd());
    return r;
  endfunction
  // Unity for 11XX, else only code 0000 (-36 dB in Q1.15) is used
  function logic [23:0] side(logic [1:0] src);
    longint p;
    logic [3:0] lv;
    lv = (src == 2'h1) ? llvl : rlvl;
    p = longint'($signed(src == 2'h1 ? hs.left : hs.right));
    p = p * ((lv[3:2] == 2'h3) ? 32'sh0000_8000 : 32'sh0000_0207);
    p = p >>> 15;
    return (!rate || src == 2'h0 || src == 2'h3) ? 24'h00_0000 : p[23:0];
  endfunction
  function logic [23:0] mix(logic [23:0] s, logic [23:0] st, logic on);
    longint v;
    v = (longint'($signed(s)) <<< g) + longint'($signed(st));
    if (v > 64'sh007F_FFFF) v = 64'sh007F_FFFF;
    if (v < -64'sh0080_0000) v = -64'sh0080_0000;
    return on ? v[23:0] : 24'h00_0000;
  endfunction
  task play(dbsm_pair_t p);
    dbsm_pair_t e;
    e.left = mix(lsel ? p.right : p.left, side(lsrc), lon_m);
    e.right = mix(rsel ? p.right : p.left, side(rsrc), ron_m);
    q.push_back(e);
    dbsm_play_src_inst.send(p);
  endtask
  task apb(logic w, logic [9:0] a, logic [31:0] d, logic [31:0] er, logic ee);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    tests_run++;
    if (pslverr !== ee || (!w && prdata !== er)) begin
      mismatches++;
      $display("BAD %0t bus access %h", $time, a);
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task drain();
    for (int k = 0; k < 2000 && q.size() > 0; k++) @(posedge clk);
    if (q.size() > 0) begin
      mismatches++;
      $display("BAD %0t stream stalled", $time);
    end
  endtask
  // Settings are only changed once the stream is empty
  task setreg(logic [9:0] a, logic [15:0] v);
    drain();
    apb(1'b1, a, {16'h0000, v}, 32'h0000_0000, 1'b0);
    case (a)
      10'h048: {lon_m, ron_m} = v[3:2];
      10'h060: {g, lsel, rsel} = {v[10:9], v[5:4]};
      default: {llvl, rlvl, lsrc, rsrc} = v[11:0];
    endcase
  endtask
  task hpf(dbsm_pair_t x);
    @(posedge clk);
    hv <= 1'b1;
    hd <= x;
    hs = x;
    @(posedge clk);
    hv <= 1'b0;
    hd <= ~x;
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) drdy <= !stall && (rnd() % 3 != 0);
  always @(posedge clk) if (!rst && dv === 1'b1 && drdy === 1'b1) begin
    tests_run++;
    if (q.size() == 0 || dd !== q[0]) begin
      mismatches++;
      $display("BAD %0t mixed sample %h", $time, dd);
    end
    if (q.size() > 0) void'(q.pop_front());
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 10'h048, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 10'h060, 32'h0, 32'h0000_0010, 1'b0);
    apb(1'b0, 10'h080, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 10'h044, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, 10'h049, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1);
    setreg(10'h048, 16'h000C);
    for (int i = 0; i < 8; i++) begin
      setreg(10'h060, {5'h00, i[2:1], 3'h0, i[0], ~i[0], 4'h0});
      repeat (4) play(rp());
    end
    setreg(10'h060, 16'h0010);
    rate <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      setreg(10'h080, {4'h0, i[3] ? 4'h0 : {2'h3, i[1:0]}, i[2] ? 4'h0 : 4'hF, i[3:0]});
      hpf(rp());
      repeat (2) play(rp());
    end
    setreg(10'h080, 16'h0CF6);
    rate <= 1'b0;
    // Let the rate flag settle before the model reads it
    @(posedge clk);
    repeat (2) play(rp());
    setreg(10'h048, 16'h0004);
    play(rp());
    repeat (3) @(posedge clk);
    tests_run++;
    if (lon !== 1'b0 || ron !== 1'b1) begin
      mismatches++;
      $display("BAD %0t converter enables", $time);
    end
    drain();
    stall <= 1'b1;
    repeat (17) play(rp());
    repeat (2) @(posedge clk);
    tests_run++;
    if (prdy !== 1'b0) begin
      mismatches++;
      $display("BAD %0t full buffer accepted", $time);
    end
    apb(1'b0, 10'h084, 32'h0, 32'h0000_0110, 1'b0);
    stall <= 1'b0;
    drain();
    tally_and_finish();
  end
endmodule // dbsm_mixer_tb
